// file: hdl/urx_pkg.sv
// package of constants and types for the uart receive buffer block
//
// Notes on behaviour
// RULE_01: with nine-bit characters software reads the ninth bit before the data byte.
// RULE_02: a data read advances the buffer read pointer to the next entry.
// RULE_03: software reads error status before the data location.
// RULE_04: receive complete reads one while any unread entry is buffered.
// RULE_05: clearing receiver enable flushes the buffer; receive complete drops.
// RULE_06: interrupt request stays high while flag, enable and global enable are set.
// RULE_07: error flags are buffered with their frame and shown for the read entry.
// RULE_08: software writes to the error flag positions have no effect.
// RULE_09: software writes zeros to the error flag positions.
// RULE_10: no error flag raises an interrupt.
// RULE_11: frame error is the inverse of the first stop bit; stop count ignored.
// RULE_12: overrun when buffer full, shifter waiting, and a new start bit arrives.
// RULE_13: overrun clears when a frame moves into the buffer.
// RULE_14: parity checked only while parity enable is set, against received parity.
// RULE_15: parity error stored only if checking was enabled when the frame arrived.
// RULE_16: parity error reads zero while checking is disabled.
// RULE_17: disabling the receiver aborts any reception at once.
// RULE_18: a disabled receiver releases the receive pin.
// RULE_19: software flushes by reading data until receive complete clears.
// RULE_20: shift to the first stop bit, ignore a second, then store the frame.
// RULE_21: unused upper data bits of short frames read as zero.
// RULE_22: setting receiver enable enables reception and claims the receive pin.
// RULE_23: parity odd select zero means even parity, one means odd.
`default_nettype none
package urx_pkg;
    // register offsets
    localparam logic [1:0] ADDR_DATA = 2'h0;    // serial_data_location
    localparam logic [1:0] ADDR_STATUS = 2'h1;  // serial_status_reg
    localparam logic [1:0] ADDR_CONTROL = 2'h2; // serial_control_reg
    localparam logic [1:0] ADDR_FORMAT = 2'h3;  // serial_format_reg
    // status bit positions
    localparam int ST_RXC = 7;
    localparam int ST_FE = 4;
    localparam int ST_DOR = 3;
    localparam int ST_UPE = 2;
    // control bit positions
    localparam int CT_RXCIE = 7;
    localparam int CT_RXEN = 4;
    localparam int CT_SZ2 = 2;
    localparam int CT_RXB8 = 1;
    // format bit positions
    localparam int FM_PEN = 5;
    localparam int FM_PODD = 4;
    localparam int FM_SBS = 3;
    localparam int FM_SZ1 = 2;
    localparam int FM_SZ0 = 1;
    // reset values
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [7:0] FORMAT_RST = 8'h06;
    // baud timing: bit time in clock cycles, half bit for start centre
    localparam int BIT_CYCLES = 16;
    localparam int HALF_CYCLES = BIT_CYCLES / 2;
    localparam int BUF_DEPTH = 2;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} urx_state_t;
endpackage : urx_pkg
`default_nettype wire

// file: hdl/urx_top.sv
// receive side of a serial transceiver with two-entry status buffer
//
// The register offsets and the address-and-strobe port were left to the implementer.
`default_nettype none
module urx_top
    import urx_pkg::*;
#(
    parameter int BIT_CYC = BIT_CYCLES
) (
    input wire logic clk,             // system clock, 50 MHz
    input wire logic rstn,            // synchronous reset, active low
    input wire logic [1:0] addr,      // register address
    input wire logic [7:0] wdata,     // write data
    input wire logic wr,              // write strobe
    input wire logic rd,              // read strobe
    input wire logic global_irq_en,   // global interrupt enable
    input wire logic serial_rx_pin,   // serial line input
    output logic [7:0] rdata,         // read data, cycle after rd
    output logic rx_irq,              // receive complete interrupt request
    output logic rx_pin_claimed       // high while receiver owns the pin
);
    // entry: {fe, dor, upe, spare, ninth, data}
    typedef struct packed {
        logic [2:0] sync;
        logic line;
        urx_state_t state;
        logic [7:0] cnt;
        logic [3:0] bitn;
        logic [10:0] shreg;
        logic waiting;
        logic [12:0] wait_ent;
        logic dor_pend;
        logic [1:0][12:0] ent;
        logic rptr;
        logic [1:0] count;
        logic [7:0] control;
        logic [7:0] format;
        logic [7:0] rdata;
        logic irq;
        logic claim;
    } urx_st_t;

    urx_st_t s_reg, s_next;

    // ----------------------------------------
    // frame decode
    // ----------------------------------------
    // frame geometry from size code
    logic [2:0] csz;
    logic [3:0] ndata;
    logic [3:0] nbits;
    logic rxen;
    logic [12:0] head;
    logic [12:0] frame_ent;
    logic [8:0] dmask;
    logic par_calc;
    logic fe_bit;
    logic par_bit;
    logic [9:0] dwide;

    always_comb begin
        csz = {s_reg.control[CT_SZ2], s_reg.format[FM_SZ1], s_reg.format[FM_SZ0]};
        unique case (csz)
            3'h0: ndata = 4'h5;
            3'h1: ndata = 4'h6;
            3'h2: ndata = 4'h7;
            3'h7: ndata = 4'h9;
            default: ndata = 4'h8;
        endcase
        nbits = ndata + {3'h0, s_reg.format[FM_PEN]} + 4'h1;
        rxen = s_reg.control[CT_RXEN];
        head = s_reg.ent[s_reg.rptr];
        // RULE_21 mask short frames
        dmask = 9'h1ff >> (4'h9 - ndata);
        // received bits sit at the top of shreg after shifting nbits - 1 in; the stop bit is not shifted
        dwide = s_reg.shreg[10:1] >> (4'hb - nbits);
        // RULE_11 first stop bit only
        fe_bit = ~s_reg.line;
        par_bit = dwide[ndata];
        // RULE_23 odd select inverts
        par_calc = (^(dwide[8:0] & dmask)) ^ s_reg.format[FM_PODD];
        // RULE_14 RULE_15 checker only while enabled
        frame_ent = {fe_bit, 1'b0,
            s_reg.format[FM_PEN] & (par_calc != par_bit), 1'b0, // bit 9 spare
            dwide[8:0] & dmask};
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    // next state
    always_comb begin
        s_next = s_reg;
        s_next.sync = {s_reg.sync[1:0], serial_rx_pin};
        if (s_reg.sync[2] == s_reg.sync[1]) begin
            s_next.line = s_reg.sync[1];
        end
        s_next.rdata = 8'h00;
        // register reads
        if (rd) begin
            unique case (addr)
                ADDR_DATA: s_next.rdata = head[7:0];
                // RULE_04 RULE_07 RULE_16 flags of head entry
                ADDR_STATUS: s_next.rdata = {s_reg.count != 2'h0, 2'h0,
                    head[12] & (s_reg.count != 2'h0),
                    head[11] & (s_reg.count != 2'h0),
                    head[10] & (s_reg.count != 2'h0) & s_reg.format[FM_PEN], 2'h0};
                ADDR_CONTROL: s_next.rdata = {s_reg.control[7:2],
                    head[8] & (s_reg.count != 2'h0), 1'b0};
                default: s_next.rdata = s_reg.format;
            endcase
        end
        // RULE_02 data read pops head
        if (rd && addr == ADDR_DATA && s_reg.count != 2'h0) begin
            s_next.rptr = ~s_reg.rptr;
            s_next.count = s_reg.count - 2'h1;
        end
        // RULE_08 status writes ignored
        if (wr && addr == ADDR_CONTROL) begin
            s_next.control = {wdata[7:2], 2'h0};
        end
        if (wr && addr == ADDR_FORMAT) begin
            s_next.format = wdata;
        end
        // move waiting frame into buffer when room opens
        if (s_reg.waiting && s_next.count != 2'h2) begin
            s_next.ent[s_next.rptr ^ s_next.count[0]] = s_reg.wait_ent;
            s_next.count = s_next.count + 2'h1;
            s_next.waiting = 1'b0;
        end
        // line state machine
        s_next.cnt = s_reg.cnt + 8'h01;
        unique case (s_reg.state)
            RX_IDLE: begin
                s_next.cnt = 8'h00;
                if (!s_reg.line) begin
                    s_next.state = RX_START;
                    // RULE_12 start with full buffer and waiting frame
                    if (s_reg.waiting && s_next.waiting) begin
                        s_next.waiting = 1'b0;
                        s_next.dor_pend = 1'b1;
                    end
                end
            end
            RX_START: begin
                if (s_reg.cnt == 8'(BIT_CYC / 2 - 1)) begin
                    s_next.cnt = 8'h00;
                    s_next.bitn = 4'h0;
                    s_next.state = s_reg.line ? RX_IDLE : RX_BITS;
                end
            end
            RX_BITS: begin
                if (s_reg.cnt == 8'(BIT_CYC - 1)) begin
                    s_next.cnt = 8'h00;
                    s_next.bitn = s_reg.bitn + 4'h1;
                    // RULE_20 stop bit ends frame, second ignored
                    if (s_reg.bitn == nbits - 4'h1) begin
                        s_next.state = RX_IDLE;
                        s_next.wait_ent = frame_ent;
                        // RULE_13 dor bit follows pending loss
                        s_next.wait_ent[11] = s_reg.dor_pend;
                        s_next.dor_pend = 1'b0;
                        if (s_next.count != 2'h2) begin
                            s_next.ent[s_next.rptr ^ s_next.count[0]] = s_next.wait_ent;
                            s_next.count = s_next.count + 2'h1;
                        end else begin
                            s_next.waiting = 1'b1;
                        end
                    end else begin
                        s_next.shreg = {s_reg.line, s_reg.shreg[10:1]};
                    end
                end
            end
            // spare state code cannot arise; recover to idle anyway
            default: s_next.state = RX_IDLE;
        endcase
        // RULE_05 RULE_17 disable flushes and aborts at once
        if (!s_next.control[CT_RXEN]) begin
            s_next.state = RX_IDLE;
            s_next.count = 2'h0;
            s_next.waiting = 1'b0;
            s_next.dor_pend = 1'b0;
        end
        // RULE_06 RULE_10 only receive complete requests
        s_next.irq = (s_next.count != 2'h0) & s_next.control[CT_RXCIE] & global_irq_en;
        // RULE_18 RULE_22 pin ownership
        s_next.claim = s_next.control[CT_RXEN];
    end

    // ----------------------------------------
    // state register and outputs
    // ----------------------------------------
    // state register
    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_reg <= '0;
            s_reg.sync <= 3'h7;
            s_reg.line <= 1'b1;
            s_reg.state <= RX_IDLE;
            s_reg.control <= CONTROL_RST;
            s_reg.format <= FORMAT_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign rdata = s_reg.rdata;
    assign rx_irq = s_reg.irq;
    assign rx_pin_claimed = s_reg.claim;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    property p_rxc_flag;
        @(posedge clk) disable iff (!rstn)
        rd && addr == ADDR_STATUS |=> rdata[ST_RXC] == ($past(s_reg.count) != 2'h0);
    endproperty
    a_rxc_flag: assert property (p_rxc_flag) else $error("rxc mismatch"); // RULE_04

    property p_flush;
        @(posedge clk) disable iff (!rstn)
        !s_next.control[CT_RXEN] |=> s_reg.count == 2'h0 && !rx_irq;
    endproperty
    a_flush: assert property (p_flush) else $error("no flush"); // RULE_05

    property p_pop;
        @(posedge clk) disable iff (!rstn)
        rd && addr == ADDR_DATA && s_reg.count != 2'h0 && rxen |=> s_reg.rptr != $past(s_reg.rptr);
    endproperty
    a_pop: assert property (p_pop) else $error("no pop"); // RULE_02

    property p_irq;
        @(posedge clk) disable iff (!rstn)
        ##1 rx_irq == ($past(s_next.count) != 2'h0 && $past(s_next.control[CT_RXCIE])
            && $past(global_irq_en));
    endproperty
    a_irq: assert property (p_irq) else $error("irq wrong"); // RULE_06

    property p_upe_off;
        @(posedge clk) disable iff (!rstn)
        rd && addr == ADDR_STATUS && !s_reg.format[FM_PEN] |=> !rdata[ST_UPE];
    endproperty
    a_upe_off: assert property (p_upe_off) else $error("upe set"); // RULE_16

    property p_claim;
        @(posedge clk) disable iff (!rstn)
        wr && addr == ADDR_CONTROL |=> rx_pin_claimed == $past(wdata[CT_RXEN]);
    endproperty
    a_claim: assert property (p_claim) else $error("pin claim"); // RULE_18

    property p_abort;
        @(posedge clk) disable iff (!rstn)
        !s_next.control[CT_RXEN] |=> s_reg.state == RX_IDLE;
    endproperty
    a_abort: assert property (p_abort) else $error("no abort"); // RULE_17

    property p_stwr;
        @(posedge clk) disable iff (!rstn)
        wr && addr == ADDR_STATUS && rxen |=> s_reg.count >= $past(s_reg.count);
    endproperty
    a_stwr: assert property (p_stwr) else $error("status write effect"); // RULE_08

    // entry path and pin checks, independent of the bus read path
    property p_overrun;
        @(posedge clk) disable iff (!rstn)
        s_reg.state == RX_IDLE && !s_reg.line && s_reg.waiting && s_reg.count == 2'h2
            && !(rd && addr == ADDR_DATA) && s_next.control[CT_RXEN] |=> s_reg.dor_pend;
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not marked"); // RULE_12

    property p_dor_clear;
        @(posedge clk) disable iff (!rstn)
        s_reg.state == RX_BITS && s_next.state == RX_IDLE |=> !s_reg.dor_pend;
    endproperty
    a_dor_clear: assert property (p_dor_clear) else $error("overrun kept"); // RULE_13

    property p_irq_source;
        @(posedge clk) disable iff (!rstn)
        rx_irq |-> s_reg.count != 2'h0 && s_reg.control[CT_RXCIE];
    endproperty
    a_irq_source: assert property (p_irq_source) else $error("irq without data"); // RULE_10

    property p_claim_level;
        @(posedge clk) disable iff (!rstn)
        rx_pin_claimed == s_reg.control[CT_RXEN];
    endproperty
    a_claim_level: assert property (p_claim_level) else $error("pin owner wrong"); // RULE_22

    property p_upe_gate;
        @(posedge clk) disable iff (!rstn)
        s_reg.state == RX_BITS && !s_reg.format[FM_PEN] |-> !frame_ent[10];
    endproperty
    a_upe_gate: assert property (p_upe_gate) else $error("parity flag ungated"); // RULE_15

    // ----------------------------------------
    // cover points
    // ----------------------------------------
    c_frame: cover property (@(posedge clk) s_reg.count == 2'h1 ##1 s_reg.count == 2'h2);
    c_over: cover property (@(posedge clk) s_next.dor_pend && !s_reg.dor_pend);
    c_irq: cover property (@(posedge clk) rx_irq);
    c_parity: cover property (@(posedge clk) s_reg.state == RX_BITS && s_next.state == RX_IDLE
        && frame_ent[10]);
    c_flush: cover property (@(posedge clk) s_reg.count != 2'h0 && !s_next.control[CT_RXEN]);
endmodule : urx_top
`default_nettype wire

// file: sim/urx_tx_model.sv
// behavioural remote serial transmitter driving the receive line
`default_nettype none
module urx_tx_model #(
    parameter int BIT_CYC = 16
) (
    input wire logic clk, // system clock
    output logic line     // serial line, idle high
);
    timeunit 1ns;
    timeprecision 1ps;

    // line idles high, no pull needed
    initial line = 1'h1;

    // ------------------------------------------------------------
    // frame driving
    // ------------------------------------------------------------
    // one bit cell, changed just after the edge so the sync flops see clean levels
    task automatic bit_out(input logic b);
        line <= b;
        repeat (BIT_CYC) @(posedge clk);
    endtask : bit_out

    // start, data lsb first, optional parity, one stop, one idle cell
    task automatic send(input logic [8:0] d, input int n, input logic pon, input logic pb,
                        input logic stop);
        @(posedge clk);
        bit_out(1'h0);
        for (int i = 0; i < n; i++) begin
            bit_out(d[i]);
        end
        if (pon) begin
            bit_out(pb);
        end
        bit_out(stop);
        bit_out(1'h1);
    endtask : send
endmodule : urx_tx_model
`default_nettype wire

// file: sim/uart_receiver_buffer_status_bench.sv
// self-checking bench for the uart receive buffer block
`default_nettype none
module uart_receiver_buffer_status_bench import urx_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BC = 16;
    logic clk = 1'h0;
    logic rstn = 1'h0;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'h0;
    logic rd = 1'h0;
    logic global_irq_en = 1'h1;
    logic line;
    logic [7:0] rdata;
    logic rx_irq;
    logic rx_pin_claimed;
    int failures = 0;
    int checked = 0;

    urx_top #(.BIT_CYC(BC)) uut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .global_irq_en(global_irq_en), .serial_rx_pin(line),
        .rdata(rdata), .rx_irq(rx_irq), .rx_pin_claimed(rx_pin_claimed));
    urx_tx_model #(.BIT_CYC(BC)) tx (.clk(clk), .line(line));

    // 50 MHz clock
    initial begin
        forever #10 clk = ~clk;
    end

    // ------------------------------------------------------------
    // access and compare tasks
    // ------------------------------------------------------------
    // case inequality so an unknown never passes
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'h1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'h0;
    endtask : wr_reg

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input string what, input logic [1:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd <= 1'h1;
        addr <= a;
        @(posedge clk);
        rd <= 1'h0;
        #1 chk(what, exp, rdata);
    endtask : rd_chk

    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test

    // hang guard well beyond the cycle count of the run
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        end_of_test();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic p;
        repeat (3) @(posedge clk);
        rstn <= 1'h1;
        rd_chk("control", ADDR_CONTROL, CONTROL_RST);
        rd_chk("format", ADDR_FORMAT, FORMAT_RST);
        rd_chk("status", ADDR_STATUS, 8'h00);
        chk("pin claim", 8'h00, {7'h00, rx_pin_claimed});
        wr_reg(ADDR_CONTROL, 8'h90);
        @(posedge clk);
        #1 chk("pin claim", 8'h01, {7'h00, rx_pin_claimed});
        // plain frame; irq follows flag and global enable
        tx.send(9'h0a5, 8, 1'h0, 1'h0, 1'h1);
        rd_chk("status", ADDR_STATUS, 8'h80);
        chk("irq", 8'h01, {7'h00, rx_irq});
        @(posedge clk);
        global_irq_en <= 1'h0;
        repeat (2) @(posedge clk);
        #1 chk("irq", 8'h00, {7'h00, rx_irq});
        @(posedge clk);
        global_irq_en <= 1'h1;
        rd_chk("data", ADDR_DATA, 8'ha5);
        rd_chk("status", ADDR_STATUS, 8'h00);
        chk("irq", 8'h00, {7'h00, rx_irq});
        // bad stop bit; status writes must not touch the flags
        tx.send(9'h05a, 8, 1'h0, 1'h0, 1'h0);
        wr_reg(ADDR_STATUS, 8'hff);
        rd_chk("status", ADDR_STATUS, 8'h90);
        wr_reg(ADDR_CONTROL, 8'h10);
        #1 chk("irq", 8'h00, {7'h00, rx_irq});
        wr_reg(ADDR_CONTROL, 8'h90);
        wr_reg(ADDR_STATUS, 8'h00);
        rd_chk("data", ADDR_DATA, 8'h5a);
        // even then odd parity, good entry ahead of a bad one
        for (int m = 0; m < 2; m++) begin
            wr_reg(ADDR_FORMAT, (m == 0) ? 8'h26 : 8'h36);
            p = (^8'h03) ^ m[0];
            tx.send(9'h003, 8, 1'h1, p, 1'h1);
            tx.send(9'h003, 8, 1'h1, ~p, 1'h1);
            rd_chk("status", ADDR_STATUS, 8'h80);
            rd_chk("data", ADDR_DATA, 8'h03);
            rd_chk("status", ADDR_STATUS, 8'h84);
            rd_chk("data", ADDR_DATA, 8'h03);
        end
        // four frames into a two-entry buffer: third is lost
        wr_reg(ADDR_FORMAT, FORMAT_RST);
        for (int i = 1; i < 5; i++) begin
            tx.send(9'(16 + i), 8, 1'h0, 1'h0, 1'h1);
        end
        rd_chk("status", ADDR_STATUS, 8'h80);
        rd_chk("data", ADDR_DATA, 8'h11);
        rd_chk("status", ADDR_STATUS, 8'h80);
        rd_chk("data", ADDR_DATA, 8'h12);
        rd_chk("status", ADDR_STATUS, 8'h88);
        rd_chk("data", ADDR_DATA, 8'h14);
        rd_chk("status", ADDR_STATUS, 8'h00);
        tx.send(9'h021, 8, 1'h0, 1'h0, 1'h1);
        rd_chk("status", ADDR_STATUS, 8'h80);
        // flush by disabling with entries pending
        tx.send(9'h022, 8, 1'h0, 1'h0, 1'h1);
        wr_reg(ADDR_CONTROL, 8'h00);
        rd_chk("status", ADDR_STATUS, 8'h00);
        chk("pin claim", 8'h00, {7'h00, rx_pin_claimed});
        chk("irq", 8'h00, {7'h00, rx_irq});
        // disable in mid-frame, re-enable once the line is idle
        wr_reg(ADDR_CONTROL, 8'h90);
        fork
            tx.send(9'h033, 8, 1'h0, 1'h0, 1'h1);
            begin
                repeat (60) @(posedge clk);
                wr_reg(ADDR_CONTROL, 8'h00);
            end
        join
        wr_reg(ADDR_CONTROL, 8'h90);
        rd_chk("status", ADDR_STATUS, 8'h00);
        // nine-bit character: ninth bit read before the low byte
        wr_reg(ADDR_CONTROL, 8'h94);
        tx.send(9'h1a5, 9, 1'h0, 1'h0, 1'h1);
        rd_chk("control", ADDR_CONTROL, 8'h96);
        rd_chk("data", ADDR_DATA, 8'ha5);
        // five data bits: upper bits masked
        wr_reg(ADDR_CONTROL, 8'h90);
        wr_reg(ADDR_FORMAT, 8'h00);
        tx.send(9'h0ff, 5, 1'h0, 1'h0, 1'h1);
        rd_chk("data", ADDR_DATA, 8'h1f);
        end_of_test();
    end
endmodule : uart_receiver_buffer_status_bench
`default_nettype wire
